// >>> shared/csm_pkg.sv
// constants and types shared by the contactor sequencing monitor
package csm_pkg;

    // time base
    localparam int CLK_HZ      = 25_000_000;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;

    // timer and setting widths
    localparam int TMR_W      = 17;
    localparam int LINE_TO_W  = 10;
    localparam int RUN_DLY_W  = 13;
    localparam int OPEN_DLY_W = 9;

    // line contactor closure timeout, seconds
    localparam int LINE_TO_MIN_S = 1;
    localparam int LINE_TO_MAX_S = 999;
    localparam int LINE_TO_DEF_S = 5;

    // run delay and open delay, in 10 ms ticks
    localparam int RUN_DLY_MAX_T  = 6000;
    localparam int RUN_DLY_DEF_T  = 15;
    localparam int OPEN_DLY_MAX_T = 500;
    localparam int OPEN_DLY_DEF_T = 10;

    // source selection for lock and feedback
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_VIRT = 2'h1;
    localparam logic [1:0] SRC_DIN  = 2'h2;

    // reset values
    localparam logic RST_LEVEL_HIGH = 1'h1;
    localparam logic RST_FLAG       = 1'h0;

    typedef enum logic [2:0] {
        LC_OPEN,
        LC_CLOSING,
        LC_CLOSED,
        LC_STOPPING,
        LC_FAULT
    } csm_lc_state_type;

endpackage

// >>> shared/csm_tmr_if.sv
// control and status of one tick-based delay timer
interface csm_tmr_if #(parameter int W = 17) ();
    logic         start;
    logic         abort;
    logic         tick;
    logic [W-1:0] limit;
    logic         running;
    logic         expired;

    modport ctl (output start, abort, tick, limit, input running, expired);
    modport tmr (input start, abort, tick, limit, output running, expired);
endinterface

// >>> core/csm_timer.sv
// restartable delay timer counting time-base ticks
module csm_timer #(
    parameter int W = 17
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    csm_tmr_if.tmr    tmr
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;
    logic         exp_q;
    logic         exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'h0;
        if (tmr.start)
        begin
            cnt_d = tmr.limit;
            run_d = 1'h1;
        end
        else if (tmr.abort)
        begin
            run_d = 1'h0;
        end
        else if (run_q)
        begin
            if (cnt_q == '0)
            begin
                run_d = 1'h0;
                exp_d = 1'h1;
            end
            else if (tmr.tick)
            begin
                cnt_d = cnt_q - W'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt_q <= '0;
            run_q <= 1'h0;
            exp_q <= 1'h0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign tmr.running = run_q;
    assign tmr.expired = exp_q;

    a_tmr_expiry_at_zero: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        run_q && cnt_q == '0 && !tmr.start && !tmr.abort |=> exp_q && !run_q)
        else $error("timer did not expire at zero count");

endmodule

// >>> core/csm_top.sv
// line and output contactor sequencing with feedback supervision
// How it works
// - line contactor closes on any run command, opens after stop once locked
// - with ramped stop, line contactor opens only at zero speed
// - drive locks when selected lock source falls to 0
// - line contactor closure watched by timeout of 1 to 999 s, default 5 s
// - lock source acts only when line or breaker pulse outputs assigned
// - lock source is virtual bit or active-low pin, default unassigned
// - output contactor close requested as soon as run becomes active
// - output contactor open requested once no motor current flows
// - feedback supervision only when a feedback source is selected
// - opened error when feedback not closed at end of run delay
// - opened error when feedback shows open while motor runs
// - closed error when feedback not open at end of open delay
// - closed error when feedback shows closed while motor stopped
// - opened error clears on falling edge of run command
// - no output contactor close while dc injection braking active
// - run delay holds motor control (only with output contactor or feedback source) and opened check, default 0.15 s
// - open delay bounds feedback open report, default 0.10 s
// - feedback active low: 0 means contactor closed
module csm_top #(
    parameter int P_TICK_CYCLES = csm_pkg::TICK_CYCLES
) (
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_run_fwd,
    input  wire logic                           i_run_rev,
    input  wire logic                           i_ramp_stop_mode,
    input  wire logic                           i_motor_zero_speed,
    input  wire logic                           i_motor_running,
    input  wire logic                           i_motor_current_on,
    input  wire logic                           i_dc_inject_active,
    input  wire logic                           i_drive_ready,
    input  wire logic                           i_fault_reset,
    input  wire logic                           i_line_cont_assigned,
    input  wire logic                           i_cb_start_assigned,
    input  wire logic                           i_cb_stop_assigned,
    input  wire logic [1:0]                     i_lock_src_sel,
    input  wire logic                           i_lock_cmd_bit,
    input  wire logic                           i_lock_pin_n,
    input  wire logic                           i_occ_assigned,
    input  wire logic [1:0]                     i_fb_src_sel,
    input  wire logic                           i_fb_cmd_bit_n,
    input  wire logic                           i_fb_pin_n,
    input  wire logic [csm_pkg::LINE_TO_W-1:0]  i_line_timeout_s,
    input  wire logic [csm_pkg::RUN_DLY_W-1:0]  i_run_delay_t,
    input  wire logic [csm_pkg::OPEN_DLY_W-1:0] i_open_delay_t,
    output logic                                o_line_contactor_cmd,
    output logic                                o_output_contactor_cmd,
    output logic                                o_motor_enable,
    output logic                                o_drive_locked,
    output logic                                o_open_error,
    output logic                                o_closed_error,
    output logic                                o_line_error
);

    localparam int TW = csm_pkg::TMR_W;
    localparam int CW = $clog2(P_TICK_CYCLES);

    csm_tmr_if #(.W(TW)) lt_if ();
    csm_tmr_if #(.W(TW)) rd_if ();
    csm_tmr_if #(.W(TW)) od_if ();

    ////////////////////////////////////////////////////////////////////////
    // time base and pin synchronisers

    logic [CW-1:0] tick_cnt_q;
    logic [CW-1:0] tick_cnt_d;
    logic          tick_q;
    logic          tick_d;
    logic [2:0]    lk_sync_q;
    logic [2:0]    lk_sync_d;
    logic [2:0]    fb_sync_q;
    logic [2:0]    fb_sync_d;
    logic          lk_filt_q;
    logic          lk_filt_d;
    logic          fb_filt_q;
    logic          fb_filt_d;

    always_comb
    begin
        tick_d     = (tick_cnt_q == CW'(P_TICK_CYCLES - 1));
        tick_cnt_d = tick_d ? '0 : tick_cnt_q + CW'(1);
        lk_sync_d  = {lk_sync_q[1:0], i_lock_pin_n};
        fb_sync_d  = {fb_sync_q[1:0], i_fb_pin_n};
        // level taken once stages two and three agree
        lk_filt_d  = (lk_sync_q[1] == lk_sync_q[2]) ? lk_sync_q[2] : lk_filt_q;
        fb_filt_d  = (fb_sync_q[1] == fb_sync_q[2]) ? fb_sync_q[2] : fb_filt_q;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'h0;
            lk_sync_q  <= {3{csm_pkg::RST_LEVEL_HIGH}};
            fb_sync_q  <= {3{csm_pkg::RST_LEVEL_HIGH}};
            lk_filt_q  <= csm_pkg::RST_LEVEL_HIGH;
            fb_filt_q  <= csm_pkg::RST_LEVEL_HIGH;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            lk_sync_q  <= lk_sync_d;
            fb_sync_q  <= fb_sync_d;
            lk_filt_q  <= lk_filt_d;
            fb_filt_q  <= fb_filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection and edges

    logic run;
    logic run_q;
    logic run_rise;
    logic run_fall;
    logic lock_en;
    logic lock_raw;
    logic lock_raw_q;
    logic fb_sup;
    logic fb_closed;

    always_comb
    begin
        run      = i_run_fwd | i_run_rev;
        run_rise = run & ~run_q;
        run_fall = ~run & run_q;
        lock_en  = (i_lock_src_sel != csm_pkg::SRC_NONE) &
                   (i_line_cont_assigned | i_cb_start_assigned |
                    i_cb_stop_assigned);
        case (i_lock_src_sel)
            csm_pkg::SRC_VIRT: lock_raw = i_lock_cmd_bit;
            csm_pkg::SRC_DIN:  lock_raw = lk_filt_q;
            default:           lock_raw = 1'h1;
        endcase
        fb_sup = (i_fb_src_sel != csm_pkg::SRC_NONE);
        case (i_fb_src_sel)
            csm_pkg::SRC_VIRT: fb_closed = ~i_fb_cmd_bit_n;
            csm_pkg::SRC_DIN:  fb_closed = ~fb_filt_q;
            default:           fb_closed = 1'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // timer limits, clamped to the allowed ranges

    logic [csm_pkg::LINE_TO_W-1:0] line_s;

    always_comb
    begin
        if (i_line_timeout_s < csm_pkg::LINE_TO_W'(csm_pkg::LINE_TO_MIN_S))
            line_s = csm_pkg::LINE_TO_W'(csm_pkg::LINE_TO_MIN_S);
        else if (i_line_timeout_s >
                 csm_pkg::LINE_TO_W'(csm_pkg::LINE_TO_MAX_S))
            line_s = csm_pkg::LINE_TO_W'(csm_pkg::LINE_TO_MAX_S);
        else
            line_s = i_line_timeout_s;
        lt_if.limit = TW'(line_s) * TW'(csm_pkg::TICKS_PER_S);
        if (i_run_delay_t > csm_pkg::RUN_DLY_W'(csm_pkg::RUN_DLY_MAX_T))
            rd_if.limit = TW'(csm_pkg::RUN_DLY_MAX_T);
        else
            rd_if.limit = TW'(i_run_delay_t);
        if (i_open_delay_t > csm_pkg::OPEN_DLY_W'(csm_pkg::OPEN_DLY_MAX_T))
            od_if.limit = TW'(csm_pkg::OPEN_DLY_MAX_T);
        else
            od_if.limit = TW'(i_open_delay_t);
        lt_if.tick = tick_q;
        rd_if.tick = tick_q;
        od_if.tick = tick_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // line contactor sequencing

    csm_pkg::csm_lc_state_type lc_q;
    csm_pkg::csm_lc_state_type lc_d;
    logic locked_q;
    logic locked_d;
    logic line_err_q;
    logic line_err_d;
    logic release_ok;
    logic lc_cmd;

    always_comb
    begin
        lc_d       = lc_q;
        lt_if.start = 1'h0;
        lt_if.abort = 1'h0;
        // without a lock source the stop itself counts as locked
        release_ok = (~lock_en | locked_q) &
                     (~i_ramp_stop_mode | i_motor_zero_speed);
        locked_d   = locked_q;
        if (run_rise)
            locked_d = 1'h0;
        if (lock_en & lock_raw_q & ~lock_raw)
            locked_d = 1'h1;
        line_err_d = i_fault_reset ? 1'h0 : line_err_q;
        case (lc_q)
            csm_pkg::LC_OPEN:
            begin
                if (i_line_cont_assigned & run & ~line_err_q)
                begin
                    lc_d        = csm_pkg::LC_CLOSING;
                    lt_if.start = 1'h1;
                end
            end
            csm_pkg::LC_CLOSING:
            begin
                if (!run)
                begin
                    lc_d        = csm_pkg::LC_STOPPING;
                    lt_if.abort = 1'h1;
                end
                else if (i_drive_ready)
                begin
                    lc_d        = csm_pkg::LC_CLOSED;
                    lt_if.abort = 1'h1;
                end
                else if (lt_if.expired)
                begin
                    lc_d       = csm_pkg::LC_FAULT;
                    line_err_d = 1'h1;
                end
            end
            csm_pkg::LC_CLOSED:
            begin
                if (!run)
                    lc_d = csm_pkg::LC_STOPPING;
            end
            csm_pkg::LC_STOPPING:
            begin
                if (run)
                    lc_d = i_drive_ready ? csm_pkg::LC_CLOSED
                                         : csm_pkg::LC_CLOSING;
                else if (release_ok)
                    lc_d = csm_pkg::LC_OPEN;
                lt_if.start = run & ~i_drive_ready;
            end
            csm_pkg::LC_FAULT:
            begin
                if (!run)
                    lc_d = csm_pkg::LC_OPEN;
            end
            default:
                lc_d = csm_pkg::LC_OPEN;
        endcase
        if (!i_line_cont_assigned)
            lc_d = csm_pkg::LC_OPEN;
        lc_cmd = (lc_q == csm_pkg::LC_CLOSING) | (lc_q == csm_pkg::LC_CLOSED) |
                 (lc_q == csm_pkg::LC_STOPPING);
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            lc_q       <= csm_pkg::LC_OPEN;
            locked_q   <= csm_pkg::RST_FLAG;
            line_err_q <= csm_pkg::RST_FLAG;
            lock_raw_q <= csm_pkg::RST_LEVEL_HIGH;
            run_q      <= 1'h0;
        end
        else
        begin
            lc_q       <= lc_d;
            locked_q   <= locked_d;
            line_err_q <= line_err_d;
            lock_raw_q <= lock_raw;
            run_q      <= run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output contactor command and feedback supervision

    logic occ_q;
    logic occ_d;
    logic rd_done_q;
    logic rd_done_d;
    logic open_err_q;
    logic open_err_d;
    logic closed_err_q;
    logic closed_err_d;
    logic open_set;
    logic closed_set;
    logic motor_stopped;
    logic motor_en;

    always_comb
    begin
        occ_d = i_occ_assigned &
                ((run & ~i_dc_inject_active) |
                 (occ_q & (run | i_motor_current_on)));
        rd_if.start = run_rise;
        rd_if.abort = run_fall;
        od_if.start = i_occ_assigned ? (occ_q & ~occ_d) : run_fall;
        od_if.abort = run_rise;
        rd_done_d = run & (rd_done_q | rd_if.expired |
                           ~(i_occ_assigned | fb_sup));
        motor_stopped = ~run & ~occ_q & ~od_if.running & ~i_motor_running;
        open_set = fb_sup & run & ~fb_closed &
                   (rd_if.expired |
                    (rd_done_q & i_motor_running));
        closed_set = fb_sup & fb_closed &
                     (od_if.expired |
                      motor_stopped);
        open_err_d = open_set | (open_err_q & ~run_fall);
        closed_err_d = closed_set | (closed_err_q & ~i_fault_reset);
        motor_en = run & rd_done_q & ~line_err_q & ~open_err_q &
                   ~closed_err_q & (~fb_sup | fb_closed) &
                   (~i_line_cont_assigned |
                    (lc_q == csm_pkg::LC_CLOSED));
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            occ_q        <= csm_pkg::RST_FLAG;
            rd_done_q    <= csm_pkg::RST_FLAG;
            open_err_q   <= csm_pkg::RST_FLAG;
            closed_err_q <= csm_pkg::RST_FLAG;
        end
        else
        begin
            occ_q        <= occ_d;
            rd_done_q    <= rd_done_d;
            open_err_q   <= open_err_d;
            closed_err_q <= closed_err_d;
        end
    end

    csm_timer #(.W(TW)) u_line_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .tmr       (lt_if)
    );

    csm_timer #(.W(TW)) u_run_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .tmr       (rd_if)
    );

    csm_timer #(.W(TW)) u_open_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .tmr       (od_if)
    );

    assign o_line_contactor_cmd   = lc_cmd;
    assign o_output_contactor_cmd = occ_q;
    assign o_motor_enable         = motor_en;
    assign o_drive_locked         = locked_q;
    assign o_open_error           = open_err_q;
    assign o_closed_error         = closed_err_q;
    assign o_line_error           = line_err_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_line_close_run: assert property (
        lc_q == csm_pkg::LC_OPEN && i_line_cont_assigned && run &&
        !line_err_q |=> o_line_contactor_cmd)
        else $error("line contactor not closed on run");
    a_ramp_zero_open: assert property (
        $fell(o_line_contactor_cmd) && $past(lc_q) == csm_pkg::LC_STOPPING &&
        $past(i_line_cont_assigned) && $past(i_ramp_stop_mode) |->
        $past(i_motor_zero_speed))
        else $error("line contactor opened before zero speed");
    a_lock_on_fall: assert property (
        lock_en && lock_raw_q && !lock_raw |=> locked_q)
        else $error("drive did not lock on source fall");
    a_occ_run_close: assert property (
        i_occ_assigned && run && !i_dc_inject_active |=> occ_q)
        else $error("output contactor not requested on run");
    a_occ_dci_hold: assert property (
        $rose(occ_q) |-> !$past(i_dc_inject_active))
        else $error("output contactor closed during dc injection");
    a_occ_open_idle: assert property (
        occ_q && !run && !i_motor_current_on |=> !occ_q)
        else $error("output contactor not released without current");
    a_no_sup_errors: assert property (
        !fb_sup |=> !$rose(open_err_q) && !$rose(closed_err_q))
        else $error("error raised without feedback source");
    a_open_err_run: assert property (
        fb_sup && run && rd_done_q && i_motor_running && !fb_closed
        |=> open_err_q)
        else $error("open feedback while running not flagged");
    a_open_err_clear: assert property (
        run_fall && !open_set |=> !open_err_q)
        else $error("opened error not cleared by run fall");
    a_line_err_stop: assert property (
        line_err_q |-> !o_motor_enable)
        else $error("motor enabled while line error latched");

endmodule

// >>> dv/csm_contactor_model.sv
// behavioural line and output contactors with their feedback contacts
module csm_contactor_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_line_cmd,
    input  wire logic       i_occ_cmd,
    input  wire logic       i_stuck_open,
    input  wire logic       i_weld,
    input  wire logic       i_no_mains,
    input  wire logic [3:0] i_delay,
    output logic            o_fb_n,
    output logic            o_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       occ_st   = 1'h0;
    logic       line_st  = 1'h0;
    logic [3:0] occ_cnt  = 4'h0;
    logic [3:0] line_cnt = 4'h0;

    // contacts follow their coil after a mechanical delay
    always @(posedge i_sys_clk)
    begin
        if (i_occ_cmd == occ_st || occ_cnt >= i_delay)
        begin
            occ_st  <= i_occ_cmd;
            occ_cnt <= 4'h0;
        end
        else
            occ_cnt <= occ_cnt + 4'h1;
        if (i_line_cmd == line_st || line_cnt >= i_delay)
        begin
            line_st  <= i_line_cmd;
            line_cnt <= 4'h0;
        end
        else
            line_cnt <= line_cnt + 4'h1;
    end

    // feedback contact reads low when closed or welded, high when stuck open on demand
    assign o_fb_n  = i_weld ? 1'h0 : (i_stuck_open | ~occ_st);
    assign o_ready = line_st & ~i_no_mains;
endmodule

// >>> dv/tb.sv
// self-checking bench for the contactor sequencing monitor
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic            sys_clk, reset, run_fwd, run_rev, ramp, zspeed;
    logic            running, cur_on, dci, fault_rst, line_asg, cbs_asg;
    logic            cbe_asg, lock_bit, lock_pin_n, occ_asg;
    logic            stuck_open, weld, no_mains;
    logic [1:0]      lock_src, fb_src;
    logic [3:0]      pdly;
    wire logic       fb_n, ready;
    // line, occ, enable, locked, open err, closed err, line err
    wire logic [6:0] outs;
    int              error_cnt, tests_run;

    csm_top #(.P_TICK_CYCLES(10)) u_dut (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_run_fwd(run_fwd),
        .i_run_rev(run_rev), .i_ramp_stop_mode(ramp),
        .i_motor_zero_speed(zspeed), .i_motor_running(running),
        .i_motor_current_on(cur_on), .i_dc_inject_active(dci),
        .i_drive_ready(ready), .i_fault_reset(fault_rst),
        .i_line_cont_assigned(line_asg), .i_cb_start_assigned(cbs_asg),
        .i_cb_stop_assigned(cbe_asg), .i_lock_src_sel(lock_src),
        .i_lock_cmd_bit(lock_bit), .i_lock_pin_n(lock_pin_n),
        .i_occ_assigned(occ_asg), .i_fb_src_sel(fb_src),
        .i_fb_cmd_bit_n(fb_n), .i_fb_pin_n(fb_n),
        .i_line_timeout_s(10'h001), .i_run_delay_t(13'h003),
        .i_open_delay_t(9'h002), .o_line_contactor_cmd(outs[6]),
        .o_output_contactor_cmd(outs[5]), .o_motor_enable(outs[4]),
        .o_drive_locked(outs[3]), .o_open_error(outs[2]),
        .o_closed_error(outs[1]), .o_line_error(outs[0]));

    csm_contactor_model u_cont (
        .i_sys_clk(sys_clk), .i_line_cmd(outs[6]), .i_occ_cmd(outs[5]),
        .i_stuck_open(stuck_open), .i_weld(weld), .i_no_mains(no_mains),
        .i_delay(pdly), .o_fb_n(fb_n), .o_ready(ready));

    initial
    begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    task results;
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [6:0] exp);
        @(negedge sys_clk);
        tests_run++;
        if (outs !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, outs);
        end
        @(posedge sys_clk);
    endtask

    task w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // random direction and contact delay for each run request
    task go(input logic on);
        logic d;
        d = 1'($urandom % 2);
        run_fwd <= on & d;
        run_rev <= on & ~d;
        if (on)
            cur_on <= 1'h1;
        pdly    <= 4'($urandom % 5 + 2);
    endtask

    // each scenario starts from reset: no outputs assigned, no lock or feedback source selected
    task rst;
        reset <= 1'h1;
        {run_fwd, run_rev, ramp, zspeed, running, cur_on, dci} <= 7'h00;
        {fault_rst, line_asg, cbs_asg, cbe_asg, occ_asg} <= 5'h00;
        {lock_bit, lock_pin_n, stuck_open, weld, no_mains} <= 5'h18;
        lock_src <= csm_pkg::SRC_NONE;
        fb_src   <= csm_pkg::SRC_NONE;
        pdly     <= 4'h3;
        w(8);
        reset <= 1'h0;
        w(1);
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        results();
    end

    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(46));
        // full sequence with both contactors and feedback
        rst();
        {line_asg, occ_asg} <= 2'h3;
        fb_src   <= csm_pkg::SRC_DIN;
        lock_src <= csm_pkg::SRC_VIRT;
        go(1'h1);
        w(1);
        chk("close request", 7'h60);
        w(60);
        chk("run enable", 7'h70);
        go(1'h0);
        running <= 1'h0;
        w(5);
        chk("stop unlocked", 7'h60);
        lock_bit <= 1'h0;
        w(5);
        chk("locked", 7'h28);
        cur_on <= 1'h0;
        w(60);
        chk("no current", 7'h08);
        // ramped stop with lock from the active-low pin
        rst();
        {line_asg, cbs_asg, cbe_asg, ramp} <= 4'hF;
        lock_src <= csm_pkg::SRC_DIN;
        go(1'h1);
        w(60);
        chk("line closed", 7'h50);
        go(1'h0);
        lock_pin_n <= 1'h0;
        w(10);
        chk("ramp hold", 7'h48);
        zspeed <= 1'h1;
        w(5);
        chk("zero speed", 7'h08);
        // line contactor never sees mains
        rst();
        {line_asg, no_mains} <= 2'h3;
        go(1'h1);
        w(900);
        chk("timeout wait", 7'h40);
        w(300);
        chk("line error", 7'h01);
        // feedback never closes, then opens while running
        rst();
        occ_asg    <= 1'h1;
        fb_src     <= csm_pkg::SRC_DIN;
        stuck_open <= 1'h1;
        go(1'h1);
        w(60);
        chk("not closed", 7'h24);
        go(1'h0);
        cur_on <= 1'h0;
        w(3);
        chk("error cleared", 7'h00);
        stuck_open <= 1'h0;
        go(1'h1);
        w(60);
        chk("closed ok", 7'h30);
        running    <= 1'h1;
        stuck_open <= 1'h1;
        w(10);
        chk("opened running", 7'h24);
        // welded contact after stop, virtual feedback
        rst();
        occ_asg <= 1'h1;
        fb_src  <= csm_pkg::SRC_VIRT;
        go(1'h1);
        w(60);
        chk("virtual closed", 7'h30);
        weld <= 1'h1;
        go(1'h0);
        cur_on <= 1'h0;
        w(60);
        chk("not opened", 7'h02);
        weld      <= 1'h0;
        fault_rst <= 1'h1;
        w(1);
        fault_rst <= 1'h0;
        w(20);
        chk("fault reset", 7'h00);
        // closes while stopped with no command assigned
        rst();
        fb_src <= csm_pkg::SRC_DIN;
        weld   <= 1'h1;
        w(20);
        chk("closed stopped", 7'h02);
        // braking withholds close, lock source without line or breaker outputs, no supervision
        rst();
        {occ_asg, dci} <= 2'h3;
        lock_src <= csm_pkg::SRC_VIRT;
        go(1'h1);
        w(60);
        chk("braking", 7'h10);
        lock_bit <= 1'h0;
        w(5);
        chk("lock inactive", 7'h10);
        dci <= 1'h0;
        w(3);
        chk("braking over", 7'h30);
        results();
    end
endmodule
